// ### irq_ctrl.sv
// Maskable and non-maskable interrupt control unit with an AHB-Lite register slave.
//
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module irq_ctrl (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        clk_en,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [31:0] irq_in,
	input  wire logic [31:0] periph_en,
	input  wire logic        nmi_n_pin,
	input  wire logic        ack_read,
	output logic             core_irq,
	output logic      [5:0]  core_vector,
	output logic             nmi_trap
);
	logic [31:0] irq_s1_q, irq_s2_q;
	logic        pin_s1_q, pin_s2_q, pin_prev_q;
	logic [15:0] mask_low_q, mask_high_q, trace_q;
	logic        arm_q, sticky_q, nmi_flag_q;
	logic [1:0]  core_en_q;
	logic [5:0]  vector_q;
	logic        wr_pend_q, rd_pend_q;
	logic [7:0]  addr_q;
	logic [31:0] rdata_d;
	logic        fall, trap, addr_ok, status_read, ack_window;
	irq_prio_if  prio ();

	irq_prio_enc u_enc (
		.p (prio.enc)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_s1_q   <= 32'h00000000;
			irq_s2_q   <= 32'h00000000;
			pin_s1_q   <= 1'b1;
			pin_s2_q   <= 1'b1;
			pin_prev_q <= 1'b1;
		end else if (clk_en) begin
			irq_s1_q   <= irq_in & irq_pkg::USED_REQ_MASK;
			irq_s2_q   <= irq_s1_q;
			pin_s1_q   <= nmi_n_pin;
			pin_s2_q   <= pin_s1_q;
			pin_prev_q <= pin_s2_q;
		end
	end

	// Requests pass peripheral enable, mask and both core enables.
	assign prio.enabled = irq_s2_q & periph_en & {mask_high_q, mask_low_q}
		& {32{&core_en_q}};
	assign fall         = pin_prev_q & ~pin_s2_q;
	assign trap         = fall & (sticky_q | arm_q);

	assign addr_ok      = hsel & hready & htrans[1];
	assign status_read  = addr_ok && !hwrite && haddr[7:0] == irq_pkg::OFS_NMI_STATUS;
	assign ack_window   = ack_read | (rd_pend_q && addr_q == irq_pkg::OFS_VECTOR);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q    <= 8'h00;
		end else if (clk_en) begin
			wr_pend_q <= addr_ok & hwrite;
			rd_pend_q <= addr_ok & ~hwrite;
			if (addr_ok) begin
				addr_q <= haddr[7:0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_low_q  <= irq_pkg::MASK_RESET;
			mask_high_q <= irq_pkg::MASK_RESET;
			core_en_q   <= 2'b00;
		end else if (clk_en && wr_pend_q) begin
			case (addr_q)
				irq_pkg::OFS_MASK_LOW: begin
					mask_low_q <= hwdata[15:0];
				end
				irq_pkg::OFS_MASK_HIGH: begin
					mask_high_q <= hwdata[15:0];
				end
				irq_pkg::OFS_CORE_ENABLE: begin
					core_en_q <= hwdata[1:0];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			arm_q    <= 1'b0;
			sticky_q <= 1'b0;
		end else if (clk_en) begin
			if (wr_pend_q && addr_q == irq_pkg::OFS_NMI_CONTROL) begin
				arm_q    <= hwdata[irq_pkg::ARM_BIT];
				sticky_q <= sticky_q | hwdata[irq_pkg::STICKY_BIT];
			end else if (trap && !sticky_q) begin
				arm_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nmi_flag_q <= 1'b0;
			nmi_trap   <= 1'b0;
		end else if (clk_en) begin
			nmi_trap <= trap;
			if (trap) begin
				nmi_flag_q <= 1'b1;
			end else if (status_read) begin
				nmi_flag_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vector_q    <= 6'h00;
			core_irq    <= 1'b0;
			core_vector <= 6'h00;
		end else if (clk_en) begin
			vector_q    <= prio.any ? prio.code : 6'h00;
			core_irq    <= prio.any;
			core_vector <= prio.any ? prio.code : 6'h00;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trace_q <= irq_pkg::TRACE_RESET;
		end else if (clk_en) begin
			if (ack_window) begin
				trace_q[irq_pkg::TRACE_READ_LSB +: 6] <= vector_q;
			end
			if (prio.any && !core_irq) begin
				trace_q[irq_pkg::TRACE_SIGNAL_LSB +: 6] <= prio.code;
			end
		end
	end

	always_comb begin
		rdata_d = 32'h00000000;
		if (addr_ok && !hwrite) begin
			case (haddr[7:0])
				irq_pkg::OFS_NMI_STATUS: begin
					rdata_d[irq_pkg::NMI_FLAG_BIT] = nmi_flag_q;
				end
				irq_pkg::OFS_NMI_CONTROL: begin
					rdata_d[irq_pkg::ARM_BIT]    = arm_q;
					rdata_d[irq_pkg::PIN_BIT]    = pin_s2_q;
					rdata_d[irq_pkg::STICKY_BIT] = sticky_q;
				end
				irq_pkg::OFS_VECTOR: begin
					rdata_d[5:0] = vector_q;
				end
				irq_pkg::OFS_MASK_LOW: begin
					rdata_d[15:0] = mask_low_q;
				end
				irq_pkg::OFS_MASK_HIGH: begin
					rdata_d[15:0] = mask_high_q;
				end
				irq_pkg::OFS_RAW_LOW: begin
					rdata_d[15:0] = irq_s2_q[15:0];
				end
				irq_pkg::OFS_RAW_HIGH: begin
					rdata_d[15:0] = irq_s2_q[31:16];
				end
				irq_pkg::OFS_TRACE: begin
					rdata_d[15:0] = trace_q;
				end
				irq_pkg::OFS_CORE_ENABLE: begin
					rdata_d[1:0] = core_en_q;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else if (clk_en) begin
			hrdata    <= rdata_d;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	property p_trap_clears_arm;
		@(posedge hclk) disable iff (!hresetn)
		clk_en && trap && !sticky_q && !wr_pend_q |=> !arm_q;
	endproperty
	a_trap_clears_arm: assert property (p_trap_clears_arm) else $error("arm kept after trap");

	property p_sticky_holds;
		@(posedge hclk) disable iff (!hresetn)
		sticky_q |=> sticky_q;
	endproperty
	a_sticky_holds: assert property (p_sticky_holds) else $error("sticky arm dropped");

	property p_no_trap_disarmed;
		@(posedge hclk) disable iff (!hresetn)
		clk_en && !arm_q && !sticky_q |=> !nmi_trap;
	endproperty
	a_no_trap_disarmed: assert property (p_no_trap_disarmed) else $error("trap while disarmed");

	property p_flag_on_trap;
		@(posedge hclk) disable iff (!hresetn)
		clk_en && trap |=> nmi_flag_q && nmi_trap;
	endproperty
	a_flag_on_trap: assert property (p_flag_on_trap) else $error("flag not set by trap");

	property p_flag_read_clear;
		@(posedge hclk) disable iff (!hresetn)
		clk_en && status_read && !trap |=> !nmi_flag_q;
	endproperty
	a_flag_read_clear: assert property (p_flag_read_clear) else $error("status not cleared by read");

	property p_irq0_dead;
		@(posedge hclk) disable iff (!hresetn)
		!irq_s2_q[0] && !irq_s2_q[12];
	endproperty
	a_irq0_dead: assert property (p_irq0_dead) else $error("unused request seen");

	property p_vector_offset;
		@(posedge hclk) disable iff (!hresetn)
		clk_en && prio.any |=> vector_q >= irq_pkg::VECTOR_OFFSET + 6'd1 && core_irq;
	endproperty
	a_vector_offset: assert property (p_vector_offset) else $error("vector code out of range");

	property p_core_gate;
		@(posedge hclk) disable iff (!hresetn)
		clk_en && !(&core_en_q) |=> !core_irq;
	endproperty
	a_core_gate: assert property (p_core_gate) else $error("request passed while disabled");

	property p_top_wins;
		@(posedge hclk) disable iff (!hresetn)
		clk_en && prio.enabled[31] |=> core_vector == 6'h2F;
	endproperty
	a_top_wins: assert property (p_top_wins) else $error("request 31 did not win");

	property p_reset_masks;
		@(posedge hclk) $rose(hresetn) |-> mask_low_q == 16'hFFFF && mask_high_q == 16'hFFFF;
	endproperty
	a_reset_masks: assert property (p_reset_masks) else $error("mask reset value wrong");

	property p_arm_traps;
		@(posedge hclk) disable iff (!hresetn)
		clk_en && arm_q && fall |=> nmi_trap;
	endproperty
	a_arm_traps: assert property (p_arm_traps) else $error("armed edge missed");

	property p_sticky_traps;
		@(posedge hclk) disable iff (!hresetn)
		clk_en && sticky_q && fall |=> nmi_trap;
	endproperty
	a_sticky_traps: assert property (p_sticky_traps) else $error("sticky edge missed");

	property p_flag_holds;
		@(posedge hclk) disable iff (!hresetn)
		clk_en && nmi_flag_q && !status_read |=> nmi_flag_q;
	endproperty
	a_flag_holds: assert property (p_flag_holds) else $error("status lost without read");

	property p_idle_vector;
		@(posedge hclk) disable iff (!hresetn)
		clk_en && !prio.any |=> core_vector == 6'h00 && !core_irq;
	endproperty
	a_idle_vector: assert property (p_idle_vector) else $error("request without winner");

	property p_mask_gate;
		@(posedge hclk) disable iff (!hresetn)
		clk_en && (irq_s2_q & periph_en & {mask_high_q, mask_low_q}) == 32'h00000000 |=> !core_irq;
	endproperty
	a_mask_gate: assert property (p_mask_gate) else $error("masked request passed");

	property p_pin_readback;
		@(posedge hclk) disable iff (!hresetn)
		clk_en && addr_ok && !hwrite && haddr[7:0] == irq_pkg::OFS_NMI_CONTROL
		|=> hrdata[irq_pkg::PIN_BIT] == $past(pin_s2_q);
	endproperty
	a_pin_readback: assert property (p_pin_readback) else $error("pin level read wrong");

	property p_vector_read_zero;
		@(posedge hclk) disable iff (!hresetn)
		clk_en && addr_ok && !hwrite && haddr[7:0] == irq_pkg::OFS_VECTOR
		|=> hrdata[31:6] == 26'h0;
	endproperty
	a_vector_read_zero: assert property (p_vector_read_zero) else $error("vector top bits set");

	property p_raw_low_read;
		@(posedge hclk) disable iff (!hresetn)
		clk_en && addr_ok && !hwrite && haddr[7:0] == irq_pkg::OFS_RAW_LOW
		|=> hrdata == {16'h0000, $past(irq_s2_q[15:0])};
	endproperty
	a_raw_low_read: assert property (p_raw_low_read) else $error("raw status read wrong");

	property p_trace_signal;
		@(posedge hclk) disable iff (!hresetn)
		clk_en && prio.any && !core_irq |=> trace_q[11:6] == $past(prio.code);
	endproperty
	a_trace_signal: assert property (p_trace_signal) else $error("trace code not kept");

	c_nmi_trap: cover property (@(posedge hclk) disable iff (!hresetn) nmi_trap);
	c_core_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(core_irq));
	c_sticky:   cover property (@(posedge hclk) disable iff (!hresetn) sticky_q && nmi_trap);
	c_clear:    cover property (@(posedge hclk) disable iff (!hresetn) status_read && nmi_flag_q);
	c_ack:      cover property (@(posedge hclk) disable iff (!hresetn) ack_window && core_irq);
endmodule : irq_ctrl

// ### irq_pkg.sv
// Package of register offsets, field positions, reset values and counts for the interrupt unit.
package irq_pkg;
	localparam logic [7:0]  OFS_NMI_STATUS   = 8'h00;
	localparam logic [7:0]  OFS_NMI_CONTROL  = 8'h04;
	localparam logic [7:0]  OFS_VECTOR       = 8'h08;
	localparam logic [7:0]  OFS_MASK_LOW     = 8'h0C;
	localparam logic [7:0]  OFS_MASK_HIGH    = 8'h10;
	localparam logic [7:0]  OFS_RAW_LOW      = 8'h14;
	localparam logic [7:0]  OFS_RAW_HIGH     = 8'h18;
	localparam logic [7:0]  OFS_TRACE        = 8'h1C;
	localparam logic [7:0]  OFS_CORE_ENABLE  = 8'h20;
	localparam int          NMI_FLAG_BIT     = 0;
	localparam int          ARM_BIT          = 0;
	localparam int          PIN_BIT          = 1;
	localparam int          STICKY_BIT       = 2;
	localparam int          GLOBAL_EN_BIT    = 0;
	localparam int          LOCAL_EN_BIT     = 1;
	localparam int          NUM_REQ          = 32;
	localparam logic [5:0]  VECTOR_OFFSET    = 6'h10;
	localparam logic [15:0] MASK_RESET       = 16'hFFFF;
	localparam logic [15:0] TRACE_RESET      = 16'h0000;
	localparam logic [31:0] USED_REQ_MASK    = 32'hFF85EFE2;
	localparam int          TRACE_READ_LSB   = 0;
	localparam int          TRACE_SIGNAL_LSB = 6;
endpackage : irq_pkg

// ### irq_prio_if.sv
// Interface that carries the enabled requests to the priority encoder and its answer back.
`timescale 1ns/1ps
interface irq_prio_if;
	logic [31:0] enabled;
	logic        any;
	logic [5:0]  code;
	modport ctrl (output enabled, input any, input code);
	modport enc  (input enabled, output any, output code);
endinterface : irq_prio_if

// ### irq_prio_enc.sv
// Priority encoder that picks the highest-numbered enabled request and forms its vector code.
`timescale 1ns/1ps
module irq_prio_enc (
	irq_prio_if.enc p
);
	always_comb begin
		p.any  = 1'b0;
		p.code = 6'h00;
		for (int i = 0; i < irq_pkg::NUM_REQ; i++) begin
			if (p.enabled[i]) begin
				p.any  = 1'b1;
				p.code = 6'(i) + irq_pkg::VECTOR_OFFSET;
			end
		end
	end
endmodule : irq_prio_enc

// ### cpu_core_model.sv
// Behavioural model of the core that acknowledges requests and reads the vector.
`timescale 1ns/1ps
module cpu_core_model (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       take_en,
	input  wire logic       core_irq,
	input  wire logic [5:0] core_vector,
	output logic            ack_read,
	output logic      [5:0] taken_vector
);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ack_read <= 1'b0;
		end else begin
			ack_read <= take_en & core_irq & ~ack_read;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			taken_vector <= 6'h00;
		end else if (ack_read) begin
			taken_vector <= core_vector;
		end
	end
endmodule : cpu_core_model

// ### maskable_nmi_interrupt_unit_test.sv
// Self-checking testbench of the interrupt unit with random and corner-case requests.
`timescale 1ns/1ps
module maskable_nmi_interrupt_unit_test;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] irq_in = 32'h0;
	logic [31:0] periph_en = 32'h0;
	logic        nmi_n_pin = 1'b1;
	logic        ack_read;
	logic        take_en = 1'b0;
	logic        clk_en = 1'b1;
	logic        core_irq;
	logic [5:0]  core_vector;
	logic [5:0]  taken_vector;
	logic        nmi_trap;
	logic [31:0] rd;
	logic [31:0] seed = 32'h24;
	logic [31:0] rq;
	logic [31:0] pn;
	int          fail_count = 0;
	int          samples_checked = 0;
	int          traps = 0;
	logic [31:0] c_req [7] = '{32'h42, 32'h80000002, 32'hFFFFFFFF, 32'h3FFFF, 32'h1, 32'h1004,
		32'h0};
	logic [31:0] c_msk [7] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h7FFFFFFF, 32'hFFFF7FFF,
		32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
	logic [7:0]  r_adr [6] = '{irq_pkg::OFS_MASK_LOW, irq_pkg::OFS_MASK_HIGH, irq_pkg::OFS_TRACE,
		irq_pkg::OFS_NMI_STATUS, irq_pkg::OFS_NMI_CONTROL, 8'h40};
	logic [31:0] r_exp [6] = '{32'hFFFF, 32'hFFFF, 32'h0, 32'h0, 32'h2, 32'h0};
	irq_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq_in(irq_in),
		.periph_en(periph_en), .nmi_n_pin(nmi_n_pin), .ack_read(ack_read),
		.core_irq(core_irq), .core_vector(core_vector), .nmi_trap(nmi_trap));
	cpu_core_model u_core (.hclk(hclk), .hresetn(hresetn), .take_en(take_en),
		.core_irq(core_irq), .core_vector(core_vector), .ack_read(ack_read),
		.taken_vector(taken_vector));
	initial begin
		forever #12.5 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		if (nmi_trap === 1'b1)
			traps++;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [31:0] win(input logic [31:0] e);
		win = 32'h0;
		for (int i = 0; i < 32; i++)
			if (e[i])
				win = i + irq_pkg::VECTOR_OFFSET;
	endfunction : win
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check
	task automatic test_done;
		$display("Checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done
	task automatic wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
		if (hreadyout !== 1'b1) begin
			fail_count++;
			test_done();
		end
	endtask : wait_ready
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask : bus
	task automatic reset_regs;
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, r_adr[i], 32'h0);
			check(rd, r_exp[i], "reset value");
		end
		check({30'h0, hreadyout, hresp}, 32'h2, "response");
	endtask : reset_regs
	task automatic apply(input logic [31:0] req, input logic [31:0] pen, input logic [31:0] msk);
		logic [31:0] e;
		logic [31:0] r;
		r = req & irq_pkg::USED_REQ_MASK;
		e = r & pen & msk;
		bus(1'b1, irq_pkg::OFS_MASK_LOW, {16'h0, msk[15:0]});
		bus(1'b1, irq_pkg::OFS_MASK_HIGH, {16'h0, msk[31:16]});
		irq_in <= req;
		periph_en <= pen;
		repeat (4) @(posedge hclk);
		check({31'h0, core_irq}, {31'h0, e != 0}, "core request");
		check({26'h0, core_vector}, win(e), "vector out");
		bus(1'b0, irq_pkg::OFS_VECTOR, 32'h0);
		check(rd, win(e), "vector reg");
		bus(1'b0, irq_pkg::OFS_TRACE, 32'h0);
		check({26'h0, rd[5:0]}, win(e), "trace read");
		bus(1'b0, irq_pkg::OFS_RAW_LOW, 32'h0);
		check(rd, {16'h0, r[15:0]}, "raw low");
		bus(1'b0, irq_pkg::OFS_RAW_HIGH, 32'h0);
		check(rd, {16'h0, r[31:16]}, "raw high");
	endtask : apply
	task automatic nmi_fall;
		nmi_n_pin <= 1'b0;
		repeat (6) @(posedge hclk);
		nmi_n_pin <= 1'b1;
		repeat (6) @(posedge hclk);
	endtask : nmi_fall
	task automatic ctrl_is(input logic [31:0] exp);
		bus(1'b0, irq_pkg::OFS_NMI_CONTROL, 32'h0);
		check(rd, exp, "nmi control");
	endtask : ctrl_is
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		reset_regs();
		for (int k = 1; k < 4; k++) begin
			bus(1'b1, irq_pkg::OFS_CORE_ENABLE, k);
			irq_in <= 32'h80000000;
			periph_en <= 32'hFFFFFFFF;
			repeat (4) @(posedge hclk);
			check({31'h0, core_irq}, {31'h0, k == 3}, "core enables");
		end
		take_en <= 1'b1;
		for (int i = 0; i < 7; i++)
			apply(c_req[i], 32'hFFFFFFFF, c_msk[i]);
		for (int i = 0; i < 24; i++) begin
			seed = lfsr(lfsr(lfsr(seed)));
			rq = seed;
			seed = lfsr(lfsr(lfsr(seed)));
			pn = seed;
			seed = lfsr(lfsr(lfsr(seed)));
			apply(rq, pn | seed, seed | rq);
		end
		apply(32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF);
		apply(32'h200, 32'hFFFFFFFF, 32'hFFFFFFFF);
		bus(1'b0, irq_pkg::OFS_TRACE, 32'h0);
		check({26'h0, rd[11:6]}, 32'h19, "trace signal");
		check({26'h0, taken_vector}, 32'h19, "taken vector");
		clk_en <= 1'b0;
		irq_in <= 32'h0;
		repeat (4) @(posedge hclk);
		check({31'h0, core_irq}, 32'h1, "frozen request");
		clk_en <= 1'b1;
		repeat (4) @(posedge hclk);
		check({31'h0, core_irq}, 32'h0, "request dropped");
		$display("maskable test done");
		bus(1'b1, irq_pkg::OFS_NMI_CONTROL, 32'h1);
		ctrl_is(32'h3);
		nmi_fall();
		nmi_fall();
		check(traps, 1, "arm traps");
		ctrl_is(32'h2);
		bus(1'b0, irq_pkg::OFS_NMI_STATUS, 32'h0);
		check(rd, 32'h1, "status set");
		bus(1'b0, irq_pkg::OFS_NMI_STATUS, 32'h0);
		check(rd, 32'h0, "status cleared");
		nmi_n_pin <= 1'b0;
		bus(1'b1, irq_pkg::OFS_NMI_CONTROL, 32'h2);
		ctrl_is(32'h0);
		nmi_n_pin <= 1'b1;
		bus(1'b1, irq_pkg::OFS_NMI_CONTROL, 32'h4);
		nmi_fall();
		nmi_fall();
		check(traps, 3, "sticky traps");
		bus(1'b1, irq_pkg::OFS_NMI_CONTROL, 32'h0);
		ctrl_is(32'h6);
		$display("nmi test done");
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		reset_regs();
		$display("reset test done");
		test_done();
	end
endmodule : maskable_nmi_interrupt_unit_test
